// ---- rtl/usc_pkg.sv ----
// Constants for the serial port control, status and bit-rate block.
// Assumes a special function register port with 8-bit addresses and data.
package usc_pkg;

	// ==========================================================
	// Register addresses and control register reset value
	localparam logic [7:0] SERIAL_CTRL_REG_ADDR = 8'h98;
	localparam logic [7:0] SERIAL_BUFFER_ADDR = 8'h99;
	localparam logic [7:0] SERIAL_CTRL_REG_RESET = 8'h00;

	// ==========================================================
	// Control register field positions
	localparam int B7_POS = 7;
	localparam int MODE_LO_POS = 6;
	localparam int MPF_POS = 5;
	localparam int REN_POS = 4;
	localparam int TX9_POS = 3;
	localparam int RX9_POS = 2;
	localparam int TDONE_POS = 1;
	localparam int RDONE_POS = 0;

	// ==========================================================
	// Mode codes {uart_mode_hi, uart_mode_lo}
	localparam logic [1:0] MODE_SHIFT = 2'h0;
	localparam logic [1:0] MODE_UART8 = 2'h1;
	localparam logic [1:0] MODE_UART9_FIXED = 2'h2;
	localparam logic [1:0] MODE_UART9_VAR = 2'h3;

	// ==========================================================
	// Timing
	localparam int M0_DIV = 6;
	localparam logic [2:0] M0_LAST = 3'(M0_DIV - 1);
	localparam logic [2:0] M0_SAMPLE = 3'h4;
	localparam logic [2:0] M0_CLK_HIGH = 3'h3;
	localparam logic [3:0] SUB_LAST = 4'hF;
	localparam logic [3:0] SAMPLE_A = 4'h7;
	localparam logic [3:0] SAMPLE_B = 4'h8;
	localparam logic [3:0] SAMPLE_C = 4'h9;
	localparam logic [3:0] STOP_IDX8 = 4'h9;
	localparam logic [3:0] STOP_IDX9 = 4'hA;
	localparam logic [2:0] M0_LAST_BIT = 3'h7;

	typedef enum logic [1:0] {USC_TX_IDLE, USC_TX_WAIT, USC_TX_ASYNC, USC_TX_SYNC} usc_tx_state_e;
	typedef enum logic [1:0] {USC_RX_IDLE, USC_RX_ASYNC, USC_RX_SYNC} usc_rx_state_e;

endpackage

// ---- rtl/usc_rate_gen.sv ----
// Sixteenth-of-bit tick generator for the asynchronous modes.
// Assumes timer1_ovf is a one-cycle pulse per timer 1 overflow.
`timescale 1ns/10ps
module usc_rate_gen (
	input wire logic clock, // CPU clock
	input wire logic reset_n, // Asynchronous reset, active low
	input wire logic variable_rate, // High in the timer-driven modes
	input wire logic rate_double, // Rate-double select
	input wire logic timer1_ovf, // Timer 1 overflow pulse
	output logic tick16 // One pulse per sixteenth of a bit
);

	// ==========================================================
	// Source select and divide-by-two prescaler
	logic half;
	wire source = variable_rate ? timer1_ovf : 1'b1;

	// Fixed 9-bit mode: clock/2 ticks give clock/32, clock ticks give clock/16
	// Variable modes: overflow/2 gives clock/192/(256-reload), overflow gives /96
	assign tick16 = source & (rate_double | half);

	// Prescaler toggles on each source event
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			half <= 1'b0;
		end else if (source) begin
			half <= ~half;
		end
	end

endmodule

// ---- rtl/usc_serial_port.sv ----
// Serial port control, status, bit-rate selection and frame engine.
// Assumes a synchronous special function register port and synchronous pins.
`timescale 1ns/10ps
module usc_serial_port (
	input wire logic clock, // CPU clock
	input wire logic reset_n, // Asynchronous reset, active low
	input wire logic [7:0] sfr_addr, // Register address
	input wire logic sfr_wr, // Register write strobe
	input wire logic sfr_rd, // Register read strobe
	input wire logic [7:0] sfr_wdata, // Register write data
	output logic [7:0] sfr_rdata, // Register read data, one cycle later
	input wire logic bit7_view_sel, // Power control bit 7 view select
	input wire logic rate_double, // Power control rate-double bit
	input wire logic timer1_ovf, // Timer 1 overflow pulse
	input wire logic rxd_in, // Receive pin level
	output logic rxd_out, // Receive pin drive in shift mode
	output logic rxd_oe, // Receive pin output enable
	output logic txd_out // Transmit pin or shift clock
);

	// ==========================================================
	// Control register state
	logic uart_mode_hi, uart_mode_lo, multiproc_filter_en, rx_enable;
	logic tx_ninth_bit, rx_ninth_bit, transmit_done_flag, receive_done_flag, framing_error;
	logic [7:0] rx_buffer;
	usc_pkg::usc_tx_state_e tx_state;
	usc_pkg::usc_rx_state_e rx_state;
	logic [9:0] tx_shift;
	logic [3:0] tx_cnt, tx_sub, rx_cnt, rx_sub;
	logic [8:0] rx_shift;
	logic [2:0] m0_phase;
	logic [1:0] samples;
	logic rxd_prev;
	logic tick16;
	logic set_ti, set_ri, set_fe, load_rx;
	logic [8:0] load_val;

	// Register access decode
	wire [1:0] mode = {uart_mode_hi, uart_mode_lo};
	wire mode_shift = (mode == usc_pkg::MODE_SHIFT);
	wire mode_nine = uart_mode_hi;
	wire variable_rate = uart_mode_lo;
	wire wr_serial_ctrl_reg = sfr_wr && (sfr_addr == usc_pkg::SERIAL_CTRL_REG_ADDR);
	wire wr_serial_buffer = sfr_wr && (sfr_addr == usc_pkg::SERIAL_BUFFER_ADDR);
	wire [3:0] stop_idx = mode_nine ? usc_pkg::STOP_IDX9 : usc_pkg::STOP_IDX8;
	wire m0_end = (m0_phase == usc_pkg::M0_LAST);
	wire tx_edge = tick16 && (tx_sub == usc_pkg::SUB_LAST);
	wire majority = (samples[0] & samples[1]) | (rxd_in & (samples[0] | samples[1]));
	wire rx_decide = tick16 && (rx_sub == usc_pkg::SAMPLE_C);
	wire bit7_read = bit7_view_sel ? framing_error : uart_mode_hi;
	wire [7:0] serial_ctrl_reg_view = {bit7_read, uart_mode_lo, multiproc_filter_en, rx_enable,
		tx_ninth_bit, rx_ninth_bit, transmit_done_flag, receive_done_flag};

	// ==========================================================
	// Bit-rate tick for the asynchronous modes
	usc_rate_gen u_rate (
		.clock(clock),
		.reset_n(reset_n),
		.variable_rate(variable_rate),
		.rate_double(rate_double),
		.timer1_ovf(timer1_ovf),
		.tick16(tick16)
	);

	// Shift-mode machine cycle phase, one bit per six clocks
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			m0_phase <= 3'h0;
		end else begin
			m0_phase <= m0_end ? 3'h0 : m0_phase + 3'h1;
		end
	end

	// ==========================================================
	// Control register writes; hardware sets win over software clears
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			{uart_mode_hi, uart_mode_lo, multiproc_filter_en, rx_enable} <= 4'h0;
			{tx_ninth_bit, transmit_done_flag, receive_done_flag, framing_error} <= 4'h0;
		end else begin
			if (wr_serial_ctrl_reg) begin
				if (bit7_view_sel) framing_error <= sfr_wdata[usc_pkg::B7_POS];
				if (!bit7_view_sel) uart_mode_hi <= sfr_wdata[usc_pkg::B7_POS];
				uart_mode_lo <= sfr_wdata[usc_pkg::MODE_LO_POS];
				multiproc_filter_en <= sfr_wdata[usc_pkg::MPF_POS];
				rx_enable <= sfr_wdata[usc_pkg::REN_POS];
				tx_ninth_bit <= sfr_wdata[usc_pkg::TX9_POS];
				transmit_done_flag <= sfr_wdata[usc_pkg::TDONE_POS];
				receive_done_flag <= sfr_wdata[usc_pkg::RDONE_POS];
			end
			if (set_fe) framing_error <= 1'b1;
			if (set_ti) transmit_done_flag <= 1'b1;
			if (set_ri) receive_done_flag <= 1'b1;
		end
	end

	// Registered read port; unmapped addresses read zero
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_rd) begin
			sfr_rdata <= (sfr_addr == usc_pkg::SERIAL_CTRL_REG_ADDR) ? serial_ctrl_reg_view :
				(sfr_addr == usc_pkg::SERIAL_BUFFER_ADDR) ? rx_buffer : 8'h00;
		end
	end

	// ==========================================================
	// Transmitter
	assign set_ti = ((tx_state == usc_pkg::USC_TX_ASYNC) && tx_edge && (tx_cnt + 4'h1 == stop_idx))
		|| ((tx_state == usc_pkg::USC_TX_SYNC) && m0_end && (tx_cnt[2:0] == usc_pkg::M0_LAST_BIT));

	// Pins: idle high, start bit low, then the shifter; shift clock in shift mode
	always_comb begin
		txd_out = 1'b1;
		rxd_out = 1'b1;
		rxd_oe = 1'b0;
		if (tx_state == usc_pkg::USC_TX_ASYNC) begin
			txd_out = (tx_cnt == 4'h0) ? 1'b0 : tx_shift[0];
		end else if (tx_state == usc_pkg::USC_TX_SYNC) begin
			txd_out = (m0_phase >= usc_pkg::M0_CLK_HIGH);
			rxd_out = tx_shift[0];
			rxd_oe = 1'b1;
		end else if (rx_state == usc_pkg::USC_RX_SYNC) begin
			txd_out = (m0_phase >= usc_pkg::M0_CLK_HIGH);
		end
	end

	// Sixteenth counter aligning transmit bit times
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tx_sub <= 4'h0;
		end else if (tick16) begin
			tx_sub <= tx_sub + 4'h1;
		end
	end

	// Frame sequencing; a buffer write always starts a new frame
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tx_state <= usc_pkg::USC_TX_IDLE;
			tx_shift <= 10'h3FF;
			tx_cnt <= 4'h0;
		end else if (wr_serial_buffer) begin
			tx_shift <= {1'b1, (mode_nine ? tx_ninth_bit : 1'b1), sfr_wdata};
			tx_cnt <= 4'h0;
			tx_state <= usc_pkg::USC_TX_WAIT;
		end else begin
			unique case (tx_state)
				usc_pkg::USC_TX_IDLE: ;
				usc_pkg::USC_TX_WAIT: begin
					if (mode_shift && m0_end) tx_state <= usc_pkg::USC_TX_SYNC;
					if (!mode_shift && tx_edge) tx_state <= usc_pkg::USC_TX_ASYNC;
				end
				usc_pkg::USC_TX_ASYNC: begin
					if (tx_edge) begin
						if (tx_cnt == stop_idx) begin
							tx_state <= usc_pkg::USC_TX_IDLE;
						end else begin
							tx_cnt <= tx_cnt + 4'h1;
							if (tx_cnt != 4'h0) tx_shift <= {1'b1, tx_shift[9:1]};
						end
					end
				end
				usc_pkg::USC_TX_SYNC: begin
					if (m0_end) begin
						tx_shift <= {1'b1, tx_shift[9:1]};
						tx_cnt <= tx_cnt + 4'h1;
						if (tx_cnt[2:0] == usc_pkg::M0_LAST_BIT) tx_state <= usc_pkg::USC_TX_IDLE;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Receiver completion: filter, ninth bit, framing check
	always_comb begin
		set_ri = 1'b0;
		set_fe = 1'b0;
		load_rx = 1'b0;
		load_val = rx_shift;
		if (rx_state == usc_pkg::USC_RX_SYNC && m0_end && rx_cnt[2:0] == usc_pkg::M0_LAST_BIT) begin
			load_rx = 1'b1;
			load_val = {1'b0, rxd_in, rx_shift[7:1]};
			set_ri = 1'b1;
		end else if (rx_state == usc_pkg::USC_RX_ASYNC && rx_decide && rx_cnt == stop_idx) begin
			set_fe = !majority;
			if (!receive_done_flag) begin
				if (mode_nine) begin
					load_rx = !multiproc_filter_en || rx_shift[8];
				end else begin
					load_rx = !multiproc_filter_en || majority;
					load_val = {majority, rx_shift[8:1]};
				end
				set_ri = load_rx;
			end
		end
	end

	// Receive buffer and ninth-bit field
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rx_buffer <= 8'h00;
			rx_ninth_bit <= 1'b0;
		end else if (load_rx) begin
			rx_buffer <= load_val[7:0];
			if (!mode_shift) rx_ninth_bit <= load_val[8];
		end
	end

	// Reception sequencing and majority sampling
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rx_state <= usc_pkg::USC_RX_IDLE;
			rx_shift <= 9'h000;
			rx_cnt <= 4'h0;
			rx_sub <= 4'h0;
			samples <= 2'h0;
			rxd_prev <= 1'b1;
		end else begin
			if (tick16) rxd_prev <= rxd_in;
			unique case (rx_state)
				usc_pkg::USC_RX_IDLE: begin
					rx_cnt <= 4'h0;
					if (rx_enable && mode_shift && !receive_done_flag
						&& tx_state == usc_pkg::USC_TX_IDLE && m0_end) begin
						rx_state <= usc_pkg::USC_RX_SYNC;
					end else if (rx_enable && !mode_shift && tick16 && rxd_prev && !rxd_in) begin
						rx_sub <= 4'h1;
						rx_state <= usc_pkg::USC_RX_ASYNC;
					end
				end
				usc_pkg::USC_RX_ASYNC: begin
					if (!rx_enable || mode_shift) begin
						rx_state <= usc_pkg::USC_RX_IDLE;
					end else if (tick16) begin
						rx_sub <= rx_sub + 4'h1;
						if (rx_sub == usc_pkg::SAMPLE_A) samples[0] <= rxd_in;
						if (rx_sub == usc_pkg::SAMPLE_B) samples[1] <= rxd_in;
						if (rx_decide) begin
							rx_cnt <= rx_cnt + 4'h1;
							if (rx_cnt == 4'h0 && majority) begin
								rx_state <= usc_pkg::USC_RX_IDLE;
							end else if (rx_cnt == stop_idx) begin
								rx_state <= usc_pkg::USC_RX_IDLE;
							end else if (rx_cnt != 4'h0) begin
								rx_shift <= {majority, rx_shift[8:1]};
							end
						end
					end
				end
				usc_pkg::USC_RX_SYNC: begin
					if (!rx_enable) begin
						rx_state <= usc_pkg::USC_RX_IDLE;
					end else if (m0_phase == usc_pkg::M0_SAMPLE) begin
						samples[0] <= rxd_in;
					end else if (m0_end) begin
						rx_shift <= {1'b0, rxd_in, rx_shift[7:1]};
						rx_cnt <= rx_cnt + 4'h1;
						if (rx_cnt[2:0] == usc_pkg::M0_LAST_BIT) begin
							rx_state <= usc_pkg::USC_RX_IDLE;
						end
					end
				end
				default: begin
					rx_state <= usc_pkg::USC_RX_IDLE;
				end
			endcase
		end
	end

endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the serial port control block.
// Assumes the bound checker and the remote station model.
`timescale 1ns/10ps
`define CHK(nm, e, g) n_compared++; if ((g) !== (e)) begin n_fail++; $display("BAD %s exp %h got %h", nm, e, g); end
module tb;
	localparam logic [7:0] CA = usc_pkg::SERIAL_CTRL_REG_ADDR;
	localparam logic [7:0] BA = usc_pkg::SERIAL_BUFFER_ADDR;
	logic clock, reset_n, sfr_wr, sfr_rd, bit7_view_sel, rate_double, timer1_ovf, rxd_in, r9, m9;
	logic rxd_out, rxd_oe, txd_out;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v, b, c, x;
	logic [9:0] g;
	logic [7:0] exp_q[$];
	int n_fail = 0, n_compared = 0, seed = 32'hbd509c42, bt;

	usc_serial_port usc_serial_port_inst (.clock, .reset_n, .sfr_addr, .sfr_wr, .sfr_rd,
		.sfr_wdata, .sfr_rdata, .bit7_view_sel, .rate_double, .timer1_ovf, .rxd_in,
		.rxd_out, .rxd_oe, .txd_out);
	usc_remote_station usc_remote_station_inst (.clock, .txd_out, .rxd_in);

	// ==========================================
	// Clock, and timer overflow every six clocks; no overflow interrupt is modelled
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	initial begin
		timer1_ovf = 1'b0;
		forever begin
			repeat (5) @(negedge clock);
			timer1_ovf = 1'b1;
			@(negedge clock);
			timer1_ovf = 1'b0;
		end
	end

	// ==========================================
	// Register access and closing
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clock);
		sfr_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clock);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge clock);
		sfr_rd = 1'b0;
		d = sfr_rdata;
	endtask
	task end_of_test;
		$display("TB: compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		#250000;
		n_fail++;
		end_of_test();
	end

	// ==========================================
	// Main sequence
	initial begin
		{sfr_wr, sfr_rd, bit7_view_sel, rate_double, m9} = 5'h00;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		reset_n = 1'b0;
		repeat (5) @(negedge clock);
		reset_n = 1'b1;
		rd(CA, v);
		`CHK("ctl reset", usc_pkg::SERIAL_CTRL_REG_RESET, v)
		rd(8'h55, v);
		`CHK("unmapped", 8'h00, v)
		// Fixed-rate nine-bit, then doubled variable-rate nine-bit
		for (int k = 0; k < 2; k++) begin
			bt = k ? 96 : 32;
			rate_double = k[0];
			r9 = 1'($random(seed));
			c = {k ? 2'h3 : 2'h2, 2'h1, r9, 3'h0};
			wr(CA, c);
			rd(CA, v);
			`CHK("ctl write", {c[7:3], m9, c[1:0]}, v)
			b = 8'($random(seed));
			fork
				wr(BA, b);
				usc_remote_station_inst.grab(bt, g);
			join
			`CHK("tx frame", {1'b1, c[3], b}, g)
			rd(CA, v);
			`CHK("tx done", 1'b1, v[1])
			b = 8'($random(seed));
			r9 = 1'($random(seed));
			usc_remote_station_inst.send(b, 1'b1, r9, 1'b1, bt);
			exp_q.push_back(b);
			m9 = r9;
			x = exp_q.pop_front();
			rd(BA, v);
			`CHK("rx byte", x, v)
			rd(CA, v);
			`CHK("rx flags", {r9, 2'h3}, v[2:0])
			for (int n = 0; n < 2; n++) begin
				wr(CA, c | 8'h20);
				usc_remote_station_inst.send(b, 1'b1, n[0], 1'b1, bt);
				if (n[0]) m9 = 1'b1;
				rd(CA, v);
				`CHK("filter", n[0], v[0])
				`CHK("filter ninth", m9, v[2])
			end
			$display("test async %0d done", k);
		end
		// Eight-bit mode: receive off, then bad stop with filter on
		rate_double = 1'b0;
		wr(CA, 8'h40);
		usc_remote_station_inst.send(8'hA5, 1'b0, 1'b0, 1'b1, 192);
		rd(CA, v);
		`CHK("rx off", {5'h08, m9, 2'h0}, v)
		wr(CA, 8'h70);
		usc_remote_station_inst.send(8'hA5, 1'b0, 1'b0, 1'b0, 192);
		bit7_view_sel = 1'b1;
		rd(CA, v);
		`CHK("framing", {5'h1E, m9, 2'h0}, v)
		wr(CA, 8'h40);
		rd(CA, v);
		`CHK("fe clear", {5'h08, m9, 2'h0}, v)
		bit7_view_sel = 1'b0;
		wr(CA, 8'hC0);
		bit7_view_sel = 1'b1;
		wr(CA, 8'h40);
		bit7_view_sel = 1'b0;
		rd(CA, v);
		`CHK("mode kept", {5'h18, m9, 2'h0}, v)
		$display("test eight-bit done");
		// Shift mode transmit, filter kept off
		wr(CA, 8'h00);
		b = 8'($random(seed));
		fork
			wr(BA, b);
			for (int i = 0; i < 8; i++) begin
				@(posedge txd_out iff rxd_oe);
				@(negedge clock);
				g = {2'h0, rxd_out, g[7:1]};
			end
		join
		`CHK("shift out", b, g[7:0])
		repeat (8) @(negedge clock);
		rd(CA, v);
		`CHK("shift done", {5'h00, m9, 2'h2}, v)
		// Shift mode receive: starts on enable with receive done clear
		b = 8'($random(seed));
		fork
			wr(CA, 8'h10);
			usc_remote_station_inst.shift_in(b);
		join
		repeat (8) @(negedge clock);
		exp_q.push_back(b);
		x = exp_q.pop_front();
		rd(BA, v);
		`CHK("shift in", x, v)
		rd(CA, v);
		`CHK("shift rx flag", {5'h02, m9, 2'h1}, v)
		$display("test shift done");
		end_of_test();
	end
endmodule

// ---- tb/usc_assertions.sv ----
// Checker for the serial port block, on top-level ports only.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/10ps
module usc_checker (
	input wire logic clock, // CPU clock
	input wire logic reset_n, // Reset, active low
	input wire logic [7:0] sfr_addr, // Address
	input wire logic sfr_wr, // Write strobe
	input wire logic sfr_rd, // Read strobe
	input wire logic [7:0] sfr_wdata, // Write data
	input wire logic [7:0] sfr_rdata, // Read data
	input wire logic bit7_view_sel, // Bit 7 view
	input wire logic rxd_out, // Shift data
	input wire logic rxd_oe, // Shift data enable
	input wire logic txd_out // Line or shift clock
);
	// ==========================================
	// Mirror of software-owned control bits
	logic [7:0] ctl_m;
	logic [6:0] oe_cnt;
	wire ctl_wr = sfr_wr && sfr_addr == usc_pkg::SERIAL_CTRL_REG_ADDR;
	wire ctl_rd = sfr_rd && sfr_addr == usc_pkg::SERIAL_CTRL_REG_ADDR;
	wire bad_rd = sfr_rd && sfr_addr != usc_pkg::SERIAL_CTRL_REG_ADDR && sfr_addr != usc_pkg::SERIAL_BUFFER_ADDR;
	wire [1:0] mode = ctl_m[7:6];

	// Mirror update and shift-enable length count
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ctl_m <= 8'h00;
			oe_cnt <= 7'h00;
		end else begin
			if (ctl_wr) begin
				ctl_m[6:3] <= sfr_wdata[6:3];
				ctl_m[7] <= bit7_view_sel ? ctl_m[7] : sfr_wdata[7];
			end
			oe_cnt <= rxd_oe ? oe_cnt + 7'h01 : 7'h00;
		end
	end

	// ==========================================
	// Properties
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	a_oe_mode_zero: assert property (rxd_oe |-> mode == 2'h0)
		else $error("shift drive outside shift mode");
	a_shift_clock: assert property (rxd_oe && $fell(txd_out) |-> !txd_out [*3] ##1 txd_out)
		else $error("shift clock phase wrong");
	a_shift_len: assert property ($fell(rxd_oe) |-> oe_cnt == 7'h30)
		else $error("shift frame not 48 clocks");
	a_unmapped_zero: assert property (bad_rd |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data moved");
	a_ctrl_view: assert property (ctl_rd && !sfr_wr && !bit7_view_sel |=> sfr_rdata[7:3] == ctl_m[7:3])
		else $error("control view wrong");
	a_idle_data_high: assert property (!rxd_oe |-> rxd_out)
		else $error("shift data not idle");
	a_start_width: assert property ($fell(txd_out) && mode != 2'h0 |-> !txd_out [*8])
		else $error("async bit too short");
	c_shift_tx: cover property ($fell(rxd_oe));
	c_async_tx: cover property ($fell(txd_out) && mode != 2'h0);
	c_ctrl_rd: cover property (ctl_rd);
	c_shift_rx: cover property ($fell(txd_out) && !rxd_oe && mode == 2'h0);
endmodule

bind usc_serial_port usc_checker usc_checker_inst (.clock, .reset_n, .sfr_addr, .sfr_wr,
	.sfr_rd, .sfr_wdata, .sfr_rdata, .bit7_view_sel, .rxd_out, .rxd_oe, .txd_out);

// ---- tb/usc_remote_station.sv ----
// Remote serial station on the transmit and receive pins.
// Assumes the bench calls its tasks; bit time is in CPU clocks.
`timescale 1ns/10ps
module usc_remote_station (
	input wire logic clock, // CPU clock
	input wire logic txd_out, // Line from the block
	output logic rxd_in // Line to the block
);
	initial rxd_in = 1'b1;

	// ==========================================
	// Send one frame, line back to mark after it
	task automatic send(input logic [7:0] b, input logic nine, input logic b9,
		input logic stop, input int bt);
		logic [10:0] f;
		int n;
		f = {stop, b9, b, 1'b0};
		n = nine ? 11 : 10;
		if (!nine) f[9] = stop;
		for (int i = 0; i < n; i++) begin
			@(negedge clock);
			rxd_in = f[i];
			repeat (bt - 1) @(negedge clock);
		end
		@(negedge clock);
		rxd_in = 1'b1;
	endtask

	// Take one nine-bit frame at mid-bit: {stop, ninth, data}
	task automatic grab(input int bt, output logic [9:0] d);
		@(negedge txd_out);
		repeat (bt / 2) @(negedge clock);
		for (int i = 0; i < 10; i++) begin
			repeat (bt) @(negedge clock);
			d = {txd_out, d[9:1]};
		end
	endtask

	// Shift-mode source: new bit after each falling shift clock, LSB first
	task automatic shift_in(input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			@(negedge txd_out);
			@(negedge clock);
			rxd_in = b[i];
		end
		repeat (6) @(negedge clock);
		rxd_in = 1'b1;
	endtask
endmodule
